// ==== mis_defines.vh ====
// timing and reset constants shared by the indication-signal block
`ifndef MIS_DEFINES_VH
`define MIS_DEFINES_VH

// ==========================================================
// clock
`define MIS_CLK_MHZ          40

// ==========================================================
// times in microseconds, as chosen for this block
`define MIS_SECOND_US        1000000
`define MIS_DEBOUNCE_US      10000
`define MIS_RING_PULSE_US    1000
`define MIS_SYNC_PULSE_US    10

// ==========================================================
// derived cycle counts (whole-microsecond times give exact counts)
`define MIS_SECOND_CYC       (`MIS_SECOND_US * `MIS_CLK_MHZ)
`define MIS_DEBOUNCE_CYC     (`MIS_DEBOUNCE_US * `MIS_CLK_MHZ)
`define MIS_RING_PULSE_CYC   (`MIS_RING_PULSE_US * `MIS_CLK_MHZ)
`define MIS_SYNC_PULSE_CYC   (`MIS_SYNC_PULSE_US * `MIS_CLK_MHZ)

// ==========================================================
// reset values
`define MIS_CARD_RST_LEVEL   1'b0
`define MIS_WDIS_RST_LEVEL   1'b1

`endif

// ==== mis_debounce.v ====
// two-flop synchroniser and debouncer for one card-presence pin
`timescale 1ns/10ps
`default_nettype none
`include "mis_defines.vh"

module mis_debounce #(
    parameter [31:0] STABLE_CYC = `MIS_DEBOUNCE_CYC
) (
    input  wire core_clk,
    input  wire rst,
    input  wire pinIn,
    output reg  levelOut,
    output reg  rosePulse,
    output reg  fellPulse
);

    reg        meta_q;
    reg        sync_q;
    reg [31:0] stableCnt_q;

    // ==========================================================
    // synchroniser: meta_q feeds only sync_q
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= `MIS_CARD_RST_LEVEL;
            sync_q <= `MIS_CARD_RST_LEVEL;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    // ==========================================================
    // debounce: level must differ for STABLE_CYC cycles in a row
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stableCnt_q <= 32'h0000_0000;
            levelOut    <= `MIS_CARD_RST_LEVEL;
            rosePulse   <= 1'b0;
            fellPulse   <= 1'b0;
        end else begin
            rosePulse <= 1'b0;
            fellPulse <= 1'b0;
            if (sync_q == levelOut) begin
                stableCnt_q <= 32'h0000_0000;
            end else if (stableCnt_q >= STABLE_CYC - 32'h0000_0001) begin
                stableCnt_q <= 32'h0000_0000;
                levelOut    <= sync_q;
                rosePulse   <= sync_q;
                fellPulse   <= ~sync_q;
            end else begin
                stableCnt_q <= stableCnt_q + 32'h0000_0001;
            end
        end
    end

endmodule // mis_debounce

`default_nettype wire

// ==== mis_indication.v ====
// indication signals of the module toward its host
`timescale 1ns/10ps
`default_nettype none
`include "mis_defines.vh"

// Contract
// - ring indicator output tells host of calls and messages
// - ring indicator pulses high on an event, low otherwise
// - power-removal-safe output high only when rails may be removed
// - both card-presence inputs have internal pull-ups, float reads high
// - card-presence rising edge means card inserted
// - card-presence falling edge means card removed
// - dead-reckoning sync pulses once every satellite second
// - while fixes occur, sync pulse aligns with satellite second boundary
// - without fix, keep pulsing each second while time uncertainty low
// - stop sync pulses once time uncertainty is high
// - wireless-disable low stops radio transmit and receive
// - wireless-disable has pull-up; floating high means radio normal
module mis_indication #(
    parameter [31:0] SECOND_CYC     = `MIS_SECOND_CYC,
    parameter [31:0] DEBOUNCE_CYC   = `MIS_DEBOUNCE_CYC,
    parameter [31:0] RING_PULSE_CYC = `MIS_RING_PULSE_CYC
) (
    input  wire core_clk,
    input  wire rst,
    // internal event sources, same clock
    input  wire ringEvent,
    input  wire railsReleased,
    input  wire gnssSecondTick,
    input  wire gnssFixValid,
    input  wire timeUncertaintyHigh,
    // pins from the host board
    input  wire card1_present_in,
    input  wire card2_present_in,
    input  wire wirelessDisable_n,
    // pins to the host, and the pad pull-up control
    output reg  ring_indicator_out,
    output reg  power_removal_safe_out,
    output reg  dead_reckoning_sync_out,
    output reg  pinPullupEnable,
    // to the modem core
    output reg  radioEnable,
    output reg  card1Present,
    output reg  card2Present,
    output reg  card1Inserted,
    output reg  card1Removed,
    output reg  card2Inserted,
    output reg  card2Removed
);

    localparam [31:0] SYNC_PULSE_CYC = `MIS_SYNC_PULSE_CYC;

    wire       c1Level;
    wire       c1Rose;
    wire       c1Fell;
    wire       c2Level;
    wire       c2Rose;
    wire       c2Fell;
    reg        wdisMeta_q;
    reg        wdisSync_q;
    reg [31:0] ringCnt_q;
    reg [31:0] secCnt_q;
    reg [31:0] syncCnt_q;
    wire       secWrap;
    reg        syncFire;

    // true at the last cycle of a count
    function lastCycle;
        input [31:0] cnt;
        input [31:0] limit;
        begin
            lastCycle = (cnt >= limit - 32'h0000_0001);
        end
    endfunction

    // ==========================================================
    // card-presence detection
    mis_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_card1 (
        .core_clk  (core_clk),
        .rst       (rst),
        .pinIn     (card1_present_in),
        .levelOut  (c1Level),
        .rosePulse (c1Rose),
        .fellPulse (c1Fell)
    );

    mis_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_card2 (
        .core_clk  (core_clk),
        .rst       (rst),
        .pinIn     (card2_present_in),
        .levelOut  (c2Level),
        .rosePulse (c2Rose),
        .fellPulse (c2Fell)
    );

    // outputs re-registered so every top output is a flop
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            card1Present  <= `MIS_CARD_RST_LEVEL;
            card2Present  <= `MIS_CARD_RST_LEVEL;
            card1Inserted <= 1'b0;
            card1Removed  <= 1'b0;
            card2Inserted <= 1'b0;
            card2Removed  <= 1'b0;
        end else begin
            card1Present  <= c1Level;
            card2Present  <= c2Level;
            card1Inserted <= c1Rose;
            card1Removed  <= c1Fell;
            card2Inserted <= c2Rose;
            card2Removed  <= c2Fell;
        end
    end

    // ==========================================================
    // pull-up control: the pad cell holds the resistor, we keep it on
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinPullupEnable <= 1'b1;
        end else begin
            pinPullupEnable <= 1'b1;
        end
    end

    // ==========================================================
    // wireless disable, active low, synchronised
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdisMeta_q  <= `MIS_WDIS_RST_LEVEL;
            wdisSync_q  <= `MIS_WDIS_RST_LEVEL;
            radioEnable <= 1'b0;
        end else begin
            wdisMeta_q  <= wirelessDisable_n;
            wdisSync_q  <= wdisMeta_q;
            // floating pin is pulled high, so radio runs by default
            radioEnable <= wdisSync_q;
        end
    end

    // ==========================================================
    // ring indicator: retriggerable fixed-width pulse
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ringCnt_q          <= 32'h0000_0000;
            ring_indicator_out <= 1'b0;
        end else if (ringEvent) begin
            // a new event restarts the width rather than being dropped
            ringCnt_q          <= 32'h0000_0000;
            ring_indicator_out <= 1'b1;
        end else if (ring_indicator_out) begin
            if (lastCycle(ringCnt_q, RING_PULSE_CYC)) begin
                ringCnt_q          <= 32'h0000_0000;
                ring_indicator_out <= 1'b0;
            end else begin
                ringCnt_q <= ringCnt_q + 32'h0000_0001;
            end
        end
    end

    // ==========================================================
    // safe power removal
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_removal_safe_out <= 1'b0;
        end else begin
            power_removal_safe_out <= railsReleased;
        end
    end

    // ==========================================================
    // dead-reckoning second timer
    assign secWrap = lastCycle(secCnt_q, SECOND_CYC);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            secCnt_q <= 32'h0000_0000;
        end else if (gnssFixValid && gnssSecondTick) begin
            // realign local second to satellite boundary
            secCnt_q <= 32'h0000_0000;
        end else if (secWrap) begin
            secCnt_q <= 32'h0000_0000;
        end else begin
            secCnt_q <= secCnt_q + 32'h0000_0001;
        end
    end

    always @* begin
        syncFire = 1'b0;
        if (!timeUncertaintyHigh) begin
            if (gnssFixValid) begin
                syncFire = gnssSecondTick;
            end else begin
                // free-run on the last alignment while time is trusted
                syncFire = secWrap;
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncCnt_q               <= 32'h0000_0000;
            dead_reckoning_sync_out <= 1'b0;
        end else if (syncFire) begin
            syncCnt_q               <= 32'h0000_0000;
            dead_reckoning_sync_out <= 1'b1;
        end else if (dead_reckoning_sync_out) begin
            // a pulse in progress finishes even if uncertainty rises
            if (lastCycle(syncCnt_q, SYNC_PULSE_CYC)) begin
                syncCnt_q               <= 32'h0000_0000;
                dead_reckoning_sync_out <= 1'b0;
            end else begin
                syncCnt_q <= syncCnt_q + 32'h0000_0001;
            end
        end
    end

endmodule // mis_indication

`default_nettype wire

// ==== mis_indication_props.sv ====
// concurrent checks on the indication block ports
`timescale 1ns/10ps
`default_nettype none
module mis_indication_props #(
    parameter int DEBOUNCE_CYC   = 8,
    parameter int RING_PULSE_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ringEvent,
    input wire logic railsReleased,
    input wire logic gnssSecondTick,
    input wire logic gnssFixValid,
    input wire logic timeUncertaintyHigh,
    input wire logic card1_present_in,
    input wire logic wirelessDisable_n,
    input wire logic ring_indicator_out,
    input wire logic power_removal_safe_out,
    input wire logic dead_reckoning_sync_out,
    input wire logic radioEnable,
    input wire logic card1Present,
    input wire logic card1Inserted,
    input wire logic card1Removed
);
    logic [31:0] ringAge_q;
    logic [31:0] highRun_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // helper counters, saturating so idle time cannot wrap them
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ringAge_q <= RING_PULSE_CYC + 1;
            highRun_q <= 32'h0;
        end else begin
            ringAge_q <= ringEvent ? 32'h1 : ringAge_q + (ringAge_q <= RING_PULSE_CYC);
            highRun_q <= card1_present_in ? highRun_q + (highRun_q < DEBOUNCE_CYC) : 32'h0;
        end
    end
    sequence pinLow4;
        !wirelessDisable_n [*4];
    endsequence
    sequence pinHigh4;
        wirelessDisable_n [*4];
    endsequence
    ring_width_a: assert property (ring_indicator_out == (ringAge_q <= RING_PULSE_CYC))
        else $error("ring level wrong");
    safe_low_a: assert property (!railsReleased |=> !power_removal_safe_out)
        else $error("power safe high too early");
    radio_off_a: assert property (pinLow4 |=> !radioEnable)
        else $error("radio not disabled");
    radio_on_a: assert property (pinHigh4 |=> radioEnable)
        else $error("radio not enabled");
    card_insert_a: assert property (card1Inserted |-> card1Present && !$past(card1Present))
        else $error("insert pulse wrong");
    card_remove_a: assert property (card1Removed |-> !card1Present && $past(card1Present))
        else $error("remove pulse wrong");
    // pin seen three edges before the pulse: second sync flop, debounce flop and the re-register
    card_filter_a: assert property (card1Inserted |-> $past(highRun_q, 3) == DEBOUNCE_CYC)
        else $error("insert before stable time");
    sync_fire_a: assert property (gnssSecondTick && gnssFixValid && !timeUncertaintyHigh
        |=> dead_reckoning_sync_out)
        else $error("sync pulse missing");
    sync_stop_a: assert property (timeUncertaintyHigh [*2]
        |-> !$rose(dead_reckoning_sync_out))
        else $error("sync pulse while uncertain");
endmodule // mis_indication_props
bind mis_indication mis_indication_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
    .RING_PULSE_CYC(RING_PULSE_CYC)) mis_indication_props_i (.core_clk, .rst, .ringEvent,
    .railsReleased, .gnssSecondTick, .gnssFixValid, .timeUncertaintyHigh, .card1_present_in,
    .wirelessDisable_n, .ring_indicator_out, .power_removal_safe_out, .dead_reckoning_sync_out,
    .radioEnable, .card1Present, .card1Inserted, .card1Removed);
`default_nettype wire

// ==== mis_host_board.sv ====
// host board model: grounds or drives high the detect and disable pins
`timescale 1ns/10ps
`default_nettype none
module mis_host_board (
    input  wire logic card1Ground,
    input  wire logic card2Ground,
    input  wire logic radioOffReq,
    output wire logic card1Pin,
    output wire logic card2Pin,
    output wire logic wdisPin_n
);
    // ==========================================
    // host grounds a pin or drives it high itself, standing in for the pad pull-up
    assign card1Pin  = card1Ground ? 1'b0 : 1'b1;
    assign card2Pin  = card2Ground ? 1'b0 : 1'b1;
    assign wdisPin_n = radioOffReq ? 1'b0 : 1'b1;
endmodule // mis_host_board
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the indication block
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int SEC = 1000;
    localparam int DEB = 8;
    localparam int RING = 20;
    logic core_clk, rst, ringEvent, railsReleased, gnssSecondTick, gnssFixValid, uncHigh;
    logic c1Gnd, c2Gnd, wdisReq, card1Pin, card2Pin, wdisPin_n;
    logic ringOut, safeOut, syncOut, pullEn, radioEn, c1P, c2P, c1Ins, c1Rem, c2Ins, c2Rem;
    int error_cnt = 0, num_checks = 0, ringHi = 0, syncHi = 0, remCnt = 0, n, s0;
    // one nibble per event pulse: card1 insert, card1 remove, card2 insert, card2 remove
    logic [15:0] evCnt = 16'h0;
    // {rails, wdisReq, c1Gnd, c2Gnd, expSafe, expRadio, expC1, expC2}
    logic [7:0] rows [4] = '{8'h34, 8'hDA, 8'h25, 8'h8F};
    mis_host_board mis_host_board_i (.card1Ground(c1Gnd), .card2Ground(c2Gnd),
        .radioOffReq(wdisReq), .card1Pin(card1Pin), .card2Pin(card2Pin), .wdisPin_n(wdisPin_n));
    mis_indication #(.SECOND_CYC(SEC), .DEBOUNCE_CYC(DEB), .RING_PULSE_CYC(RING))
        mis_indication_i (
        .core_clk(core_clk), .rst(rst), .ringEvent(ringEvent), .railsReleased(railsReleased),
        .gnssSecondTick(gnssSecondTick), .gnssFixValid(gnssFixValid),
        .timeUncertaintyHigh(uncHigh), .card1_present_in(card1Pin), .card2_present_in(card2Pin),
        .wirelessDisable_n(wdisPin_n), .ring_indicator_out(ringOut),
        .power_removal_safe_out(safeOut),
        .dead_reckoning_sync_out(syncOut), .pinPullupEnable(pullEn), .radioEnable(radioEn),
        .card1Present(c1P), .card2Present(c2P), .card1Inserted(c1Ins), .card1Removed(c1Rem),
        .card2Inserted(c2Ins), .card2Removed(c2Rem));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        ringHi <= ringHi + int'(ringOut);
        syncHi <= syncHi + int'(syncOut);
        remCnt <= remCnt + int'(c1Rem);
        evCnt  <= evCnt + {3'h0, c1Ins, 3'h0, c1Rem, 3'h0, c2Ins, 3'h0, c2Rem};
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        {rst, ringEvent, railsReleased, gnssSecondTick, gnssFixValid, uncHigh} = 6'h20;
        {c1Gnd, c2Gnd, wdisReq} = 3'h6;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge core_clk) {railsReleased, wdisReq, c1Gnd, c2Gnd} <= rows[i][7:4];
            repeat (20) @(posedge core_clk);
            @(negedge core_clk);
            chk("power safe", 16'(rows[i][3]), 16'(safeOut));
            chk("radio enable", 16'(rows[i][2]), 16'(radioEn));
            chk("card present", 16'(rows[i][1:0]), 16'({c1P, c2P}));
            $display("test row %0d done", i);
        end
        // rows give card1 in, out, in and card2 in once, each a single pulse
        chk("card events", 16'h2110, evCnt);
        // ==========================================
        // short ground pulse on a present card must be filtered
        s0 = remCnt;
        @(posedge core_clk) c1Gnd <= 1'b1;
        repeat (DEB - 3) @(posedge core_clk);
        c1Gnd <= 1'b0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        chk("glitch removal", 16'(s0), 16'(remCnt));
        chk("card1 kept", 16'h1, 16'(c1P));
        $display("test glitch done");
        s0 = ringHi;
        @(posedge core_clk) ringEvent <= 1'b1;
        @(posedge core_clk) ringEvent <= 1'b0;
        repeat (9) @(posedge core_clk);
        ringEvent <= 1'b1;
        @(posedge core_clk) ringEvent <= 1'b0;
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        chk("ring high cycles", 16'(RING + 10), 16'(ringHi - s0));
        $display("test ring done");
        @(posedge core_clk) {gnssSecondTick, gnssFixValid} <= 2'h3;
        @(posedge core_clk) {gnssSecondTick, gnssFixValid} <= 2'h0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(syncOut === 1'b1 && n > 400) && n < 3000);
        chk("free-run period", 16'(SEC + 1), 16'(n));
        @(posedge core_clk) uncHigh <= 1'b1;
        s0 = syncHi;
        repeat (2 * SEC) @(posedge core_clk);
        @(negedge core_clk);
        chk("no pulses when uncertain", 16'h1, 16'(syncHi - s0 <= 400));
        $display("test sync done");
        @(posedge core_clk) rst <= 1'b1;
        @(negedge core_clk);
        chk("in reset", 16'h1, 16'({ringOut, safeOut, syncOut, radioEn, c1P, c2P, pullEn}));
        @(posedge core_clk) rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("radio after reset", 16'h3, 16'({radioEn, safeOut}));
        $display("test reset done");
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
